// ==== clk_stop_defines.svh ====
// constants of the clock stop and power-down control
// assumes a single 200 MHz control clock; included by its bare name
`ifndef CLK_STOP_DEFINES_SVH
`define CLK_STOP_DEFINES_SVH

// output counts
`define N_CPU 2
`define N_PCI 6
`define N_PCIF 3

// control clock period and power-up latency, each in its own unit
`define MCLK_PERIOD_NS 5.0
`define PD_WAKE_MS 3.0
// cycles kept back from the wake count: pin sync, state change and the slowest restart edge
`define WAKE_SPARE 33

// default output dividers (cpu outputs toggle every control cycle)
`define PCI_DIV_DEF 6
`define REF_DIV_DEF 14

// stop request qualification: low level seen on this many cpu edges
`define STOP_SAMPLES 2'h2

// cpu true-output drive current, as multiples of the reference current
`define DRIVE_X4 3'h4
`define DRIVE_X6 3'h6
`define DRIVE_X2 3'h2

// idle (released) level of the three synchronised stop pins
`define SYNC_IDLE 3'h7

`endif

// ==== clk_stop_pkg.sv ====
// types shared by the clock stop and power-down control
// assumes clk_stop_defines.svh sits in the include path
package clk_stop_pkg;
`include "clk_stop_defines.svh"

  // static configuration written by the serial configuration logic
  typedef struct packed {
    logic [`N_CPU-1:0] cpu_stoppable; // 1: cpu pair halts on cpu stop
    logic [`N_PCIF-1:0] pci_free_run; // 1: free pci clock ignores pci stop
    logic pci_stop_bit; // written pci run bit, low stops pci clocks
    logic drive_current_select; // 0: 4x reference, 1: 6x reference
  } cfg_t;

  // power management sequence
  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_PARK = 2'b01,
    PM_OFF = 2'b10,
    PM_WAKE = 2'b11
  } pm_state_t;

endpackage : clk_stop_pkg

// ==== clock_stop_powerdown_control.sv ====
// output stop and power-down control of a multi-output clock synthesizer
// assumes cfg comes from logic on mclk; the three stop pins are asynchronous
//
// Summary of operation
// R1 - cpu stop halts only stoppable cpu pairs
// R2 - stop after two low falling-edge samples
// R3 - stopped cpu: true high, complement low
// R4 - drive current unchanged, complement undriven while stopped
// R5 - cpu restart without runt or stretched pulse
// R6 - cpu outputs toggle within two cycles
// R7 - pci stop halts pci outputs synchronously
// R8 - free-running pci clocks ignore pci stop
// R9 - pci clocks restart within two periods
// R10 - pci stop is pin and config bit
// R11 - config bit reads zero while pci stopped
// R12 - power-down pin synchronised before use
// R13 - power-down holds pci and ref outputs low, oscillator off
// R14 - power-down parks every clock glitch-free
// R15 - two complement rising samples, park at fall
// R16 - power-down: true high at 2x, complement undriven
// R17 - reference clock may take several cycles
// R18 - clocks running within 3.0 ms of release
// R19 - termination power-good input is ignored
// R20 - sync requests, gate only at parked level
`include "clk_stop_defines.svh"
module clock_stop_powerdown_control #(
  parameter int unsigned PCI_DIV = `PCI_DIV_DEF, // control cycles per pci period
  parameter int unsigned REF_DIV = `REF_DIV_DEF, // control cycles per ref period
  parameter int unsigned WAKE_CYCLES = $rtoi(`PD_WAKE_MS * 1.0e6 / `MCLK_PERIOD_NS) - `WAKE_SPARE
) (
  input wire logic mclk, // control clock, 200 MHz
  input wire logic nrst, // synchronous reset, active low
  input wire logic cpu_clock_stop_n, // cpu stop pin, asynchronous
  input wire logic pci_clock_stop_n, // pci stop pin, asynchronous
  input wire logic power_down_n, // power-down pin, asynchronous
  input wire logic termination_power_good, // ignored by design
  input wire clk_stop_pkg::cfg_t cfg, // static configuration
  output logic [`N_CPU-1:0] cpu_clk_true, // cpu true outputs
  output logic [`N_CPU-1:0] cpu_clk_complement, // cpu complement outputs
  output logic [`N_CPU-1:0] cpu_compl_oe, // complement driven when high
  output logic [2:0] cpu_drive_mult, // true-output current in reference units
  output logic [`N_PCI-1:0] pci_clk, // stoppable pci outputs
  output logic [`N_PCIF-1:0] pci_free_clk, // pci outputs with free-run option
  output logic ref_clk, // reference clock output
  output logic osc_pll_enable, // oscillator and pll power, high = on
  output logic pci_stop_readback // readback of the pci run bit
);
  import clk_stop_pkg::*;
  localparam int unsigned PCW = $clog2(PCI_DIV);
  localparam int unsigned RCW = $clog2(REF_DIV);
  localparam int unsigned WCW = $clog2(WAKE_CYCLES + 1);
  localparam logic [PCW-1:0] PCI_LAST = PCW'(PCI_DIV - 1);
  localparam logic [PCW-1:0] PCI_HALF = PCW'(PCI_DIV / 2 - 1);
  localparam logic [RCW-1:0] REF_LAST = RCW'(REF_DIV - 1);
  localparam logic [RCW-1:0] REF_HALF = RCW'(REF_DIV / 2 - 1);
  localparam logic [WCW-1:0] WAKE_LAST = WCW'(WAKE_CYCLES);

  // next state of a gate: it closes only on the park event, opens only on the run event
  function automatic logic gate_next(input logic gate, input logic want,
                                     input logic park_ev, input logic run_ev);
    gate_next = want ? (gate | park_ev) : (gate & ~run_ev);
  endfunction : gate_next

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the first stage feeds only the second

  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic cpu_stop_s;
  logic pci_s;
  logic pd_s;

  // all three pins double-flopped; the power-down pin is treated as fully asynchronous
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sync1_q <= `SYNC_IDLE;
      sync2_q <= `SYNC_IDLE;
    end else begin
      sync1_q <= {cpu_clock_stop_n, pci_clock_stop_n, power_down_n}; // R12 R20
      sync2_q <= sync1_q;
    end
  end

  assign cpu_stop_s = sync2_q[2];
  assign pci_s = sync2_q[1];
  assign pd_s = sync2_q[0];

  ////////////////////////////////////////////////////////////////////////////////
  // output clock phase generators

  logic cpu_ph_q;
  logic cpu_rise;
  logic cpu_fall;
  logic [PCW-1:0] pci_cnt_q;
  logic [PCW-1:0] pci_cnt_d;
  logic pci_rise;
  logic pci_fall;
  logic pci_ph_d;
  logic [RCW-1:0] ref_cnt_q;
  logic [RCW-1:0] ref_cnt_d;
  logic ref_rise;
  logic ref_fall;
  logic ref_ph_d;

  // cpu true phase toggles every cycle; a fall here is a complement rising edge
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cpu_ph_q <= 1'h0;
    end else begin
      cpu_ph_q <= ~cpu_ph_q;
    end
  end

  assign cpu_rise = ~cpu_ph_q;
  assign cpu_fall = cpu_ph_q;

  // dividers keep counting while parked; reset at the last count so the first pulse is full
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pci_cnt_q <= PCI_LAST;
      ref_cnt_q <= REF_LAST;
    end else begin
      pci_cnt_q <= pci_cnt_d;
      ref_cnt_q <= ref_cnt_d;
    end
  end

  assign pci_rise = (pci_cnt_q == PCI_LAST);
  assign pci_fall = (pci_cnt_q == PCI_HALF);
  assign pci_cnt_d = pci_rise ? '0 : pci_cnt_q + PCW'(1);
  assign pci_ph_d = (pci_cnt_d <= PCI_HALF);
  assign ref_rise = (ref_cnt_q == REF_LAST);
  assign ref_fall = (ref_cnt_q == REF_HALF);
  assign ref_cnt_d = ref_rise ? '0 : ref_cnt_q + RCW'(1);
  assign ref_ph_d = (ref_cnt_d <= REF_HALF);

  ////////////////////////////////////////////////////////////////////////////////
  // cpu stop qualification

  logic [1:0] cstop_cnt_q;
  logic cpu_stop_req;

  // counts falling cpu edges that saw stop low; release clears at once to cut latency
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cstop_cnt_q <= 2'h0;
    end else if (cpu_stop_s) begin
      cstop_cnt_q <= 2'h0;
    end else if (cpu_fall && cstop_cnt_q != `STOP_SAMPLES) begin
      cstop_cnt_q <= cstop_cnt_q + 2'h1; // R2
    end
  end

  assign cpu_stop_req = (cstop_cnt_q == `STOP_SAMPLES);

  ////////////////////////////////////////////////////////////////////////////////
  // power management sequence

  pm_state_t pm_q;
  logic [1:0] pd_cnt_q;
  logic [WCW-1:0] wake_cnt_q;
  logic pd_hold;
  logic all_parked;
  logic [`N_CPU-1:0] cpu_gate_q;
  logic [`N_PCI-1:0] pci_gate_q;
  logic [`N_PCIF-1:0] pcif_gate_q;
  logic ref_gate_q;

  assign pd_hold = (pm_q != PM_RUN);
  assign all_parked = (&cpu_gate_q) & (&pci_gate_q) & (&pcif_gate_q) & ref_gate_q;

  // power-down samples taken on complement rising edges, two in a row
  always_ff @(posedge mclk) begin
    if (!nrst || pd_s || pm_q != PM_RUN) begin
      pd_cnt_q <= 2'h0;
    end else if (cpu_fall && pd_cnt_q != `STOP_SAMPLES) begin
      pd_cnt_q <= pd_cnt_q + 2'h1; // R15
    end
  end

  // run, park all outputs, power off, then wait for the pll before release
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pm_q <= PM_RUN;
    end else begin
      unique case (pm_q)
        PM_RUN: if (pd_cnt_q == `STOP_SAMPLES) pm_q <= PM_PARK; // R15
        PM_PARK: if (all_parked) pm_q <= PM_OFF; // R14 R17
        PM_OFF: if (pd_s) pm_q <= PM_WAKE;
        PM_WAKE: begin
          if (!pd_s) pm_q <= PM_OFF;
          else if (wake_cnt_q == WAKE_LAST) pm_q <= PM_RUN; // R18
        end
      endcase
    end
  end

  // power-up latency counter, only counts in the wake state
  always_ff @(posedge mclk) begin
    if (!nrst || pm_q != PM_WAKE) begin
      wake_cnt_q <= '0;
    end else begin
      wake_cnt_q <= wake_cnt_q + WCW'(1); // R18
    end
  end

  // oscillator and plls off only once every output sits parked
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      osc_pll_enable <= 1'h1;
    end else begin
      osc_pll_enable <= (pm_q != PM_OFF) && !(pm_q == PM_PARK && all_parked); // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // cpu output gating: parked high, closes on a rise, reopens on a fall

  logic [`N_CPU-1:0] cpu_gate_d;

  always_comb begin
    for (int i = 0; i < `N_CPU; i++) begin
      cpu_gate_d[i] = gate_next(cpu_gate_q[i], (cpu_stop_req && cfg.cpu_stoppable[i]) || pd_hold,
                                cpu_rise, cpu_fall); // R1 R5 R6 R20
    end
  end

  // stopped pair: true held high, complement released to the external pull-down
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cpu_gate_q <= '0;
      cpu_clk_true <= '0;
      cpu_clk_complement <= '1;
      cpu_compl_oe <= '1;
    end else begin
      cpu_gate_q <= cpu_gate_d;
      cpu_clk_true <= cpu_gate_d | {`N_CPU{~cpu_ph_q}}; // R3
      cpu_clk_complement <= ~cpu_gate_d & {`N_CPU{cpu_ph_q}}; // R3
      cpu_compl_oe <= ~cpu_gate_d; // R4 R16
    end
  end

  // drive strength only drops to the hold value once the synthesizer is off
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cpu_drive_mult <= `DRIVE_X4;
    end else if (pm_q == PM_OFF || (pm_q == PM_PARK && all_parked)) begin
      cpu_drive_mult <= `DRIVE_X2; // R16
    end else begin
      cpu_drive_mult <= cfg.drive_current_select ? `DRIVE_X6 : `DRIVE_X4; // R4
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pci and reference gating: parked low, closes on a fall, reopens on a rise

  logic pci_stop_eff;
  logic [`N_PCI-1:0] pci_gate_d;
  logic [`N_PCIF-1:0] pcif_gate_d;
  logic ref_gate_d;

  assign pci_stop_eff = !(pci_s && cfg.pci_stop_bit); // R10

  always_comb begin
    for (int j = 0; j < `N_PCI; j++) begin
      pci_gate_d[j] = gate_next(pci_gate_q[j], pci_stop_eff || pd_hold,
                                pci_fall, pci_rise); // R7 R9 R20
    end
    for (int k = 0; k < `N_PCIF; k++) begin
      pcif_gate_d[k] = gate_next(pcif_gate_q[k],
                                 (pci_stop_eff && !cfg.pci_free_run[k]) || pd_hold,
                                 pci_fall, pci_rise); // R8
    end
    ref_gate_d = gate_next(ref_gate_q, pd_hold, ref_fall, ref_rise); // R14 R17
  end

  // termination_power_good drives nothing: clock behaviour never depends on it (R19)
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pci_gate_q <= '0;
      pcif_gate_q <= '0;
      ref_gate_q <= 1'h0;
      pci_clk <= '0;
      pci_free_clk <= '0;
      ref_clk <= 1'h0;
    end else begin
      pci_gate_q <= pci_gate_d;
      pcif_gate_q <= pcif_gate_d;
      ref_gate_q <= ref_gate_d;
      pci_clk <= ~pci_gate_d & {`N_PCI{pci_ph_d}}; // R13
      pci_free_clk <= ~pcif_gate_d & {`N_PCIF{pci_ph_d}}; // R13
      ref_clk <= ~ref_gate_d & ref_ph_d; // R13
    end
  end

  // readback shows zero one cycle after either control goes low
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pci_stop_readback <= 1'h1;
    end else begin
      pci_stop_readback <= !pci_stop_eff; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions and covers

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_cpu_park_level: assert property (cpu_gate_q[0] |-> cpu_clk_true[0] && !cpu_compl_oe[0]) // R3
    else $error("stopped cpu pair not parked true high with complement undriven");

  a_cpu_two_samples: assert property ($rose(cpu_stop_req) |->
                                      $past(!cpu_stop_s, 1) && $past(!cpu_stop_s, 3)) // R2
    else $error("cpu stop taken without two low samples");

  a_cpu_only_stoppable: assert property ($rose(cpu_gate_q[0]) |->
                                         $past(pd_hold || (cpu_stop_req && cfg.cpu_stoppable[0]))) // R1
    else $error("cpu output stopped without a stop request for it");

  a_cpu_restart_time: assert property ($fell(cpu_stop_req) && !pd_hold |-> ##[1:3] !cpu_gate_q[0]) // R6
    else $error("cpu output not restarted within two cpu cycles");

  a_cpu_restart_clean: assert property ($fell(cpu_gate_q[0]) |-> !cpu_clk_true[0] ##1 cpu_clk_true[0]) // R5
    else $error("cpu restart produced a runt or stretched pulse");

  a_drive_unchanged: assert property (pm_q != PM_OFF && $past(pm_q != PM_OFF) |->
    cpu_drive_mult == ($past(cfg.drive_current_select) ? `DRIVE_X6 : `DRIVE_X4)) // R4
    else $error("cpu drive current changed outside power-down");

  a_pci_park_clean: assert property ($rose(pci_gate_q[0]) |-> !pci_clk[0] && $past(pci_clk[0])) // R7
    else $error("pci output parked other than on a falling transition");

  a_pci_stop_cause: assert property ($rose(pci_gate_q[0]) |-> $past(pci_stop_eff || pd_hold)) // R10
    else $error("pci output stopped with pin and run bit both high");

  a_pci_free_run: assert property ($rose(pcif_gate_q[0]) |-> $past(pd_hold || !cfg.pci_free_run[0])) // R8
    else $error("free-running pci clock was stopped by pci stop");

  a_pci_restart_time: assert property ($fell(pci_stop_eff) && !pd_hold |-> ##[1:12] !pci_gate_q[0]) // R9
    else $error("pci clock not restarted within two pci periods");

  a_pci_readback: assert property (!pci_s |=> !pci_stop_readback) // R11
    else $error("readback shows pci running while pin is low");

  a_pd_two_samples: assert property ($rose(pd_hold) |-> $past(!pd_s, 2) && $past(!pd_s, 4)) // R15
    else $error("power-down taken without two low samples");

  a_pd_outputs_off: assert property (pm_q == PM_OFF |->
                                     pci_clk == '0 && pci_free_clk == '0 && !ref_clk &&
                                     !osc_pll_enable) // R13
    else $error("output running or pll enabled while powered down");

  a_pd_cpu_hold: assert property (pm_q == PM_OFF |-> cpu_clk_true == '1 && cpu_compl_oe == '0 &&
                                  cpu_drive_mult == `DRIVE_X2) // R16
    else $error("cpu pair not held at 2x drive during power-down");

  a_ref_park_clean: assert property ($rose(ref_gate_q) |-> !ref_clk && $past(ref_clk)) // R14
    else $error("reference clock parked with a glitch");

  a_wake_bound: assert property (pm_q == PM_WAKE && pd_s && wake_cnt_q == WAKE_LAST |=>
                                 pm_q == PM_RUN) // R18
    else $error("clocks not released at the end of the power-up latency");

  c_cpu_stop: cover property ($rose(cpu_gate_q[0]) ##[1:40] $fell(cpu_gate_q[0]));
  c_pci_stop: cover property ($rose(pci_gate_q[0]) ##[1:60] $fell(pci_gate_q[0]));
  c_pd_cycle: cover property (pm_q == PM_OFF ##[1:40] pm_q == PM_WAKE);
  c_pd_resume: cover property (pm_q == PM_WAKE ##1 pm_q == PM_RUN);
endmodule : clock_stop_powerdown_control

// ==== pm_host_model.sv ====
// chipset power-management model driving the three stop pins of the clock block
// assumes the bench raises its requests by non-blocking assignment on falling mclk
module pm_host_model (
  input wire logic mclk, // control clock
  input wire logic want_cpu_stop, // request a cpu clock stop
  input wire logic want_pci_stop, // request a pci clock stop
  input wire logic want_pd, // request power-down
  output logic cpu_clock_stop_n, // cpu stop pin
  output logic pci_clock_stop_n, // pci stop pin
  output logic power_down_n // power-down pin
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////////
  // pins idle high while nothing is asked and move one falling edge after the request,
  // well away from the sampling edge; unknown only before the first falling edge, in reset
  always @(negedge mclk) begin
    cpu_clock_stop_n <= !want_cpu_stop;
    pci_clock_stop_n <= !want_pci_stop;
    power_down_n <= !want_pd;
  end
endmodule : pm_host_model

// ==== test_clock_stop_powerdown_control.sv ====
// self-checking bench of the clock stop and power-down control
// assumes clk_stop_pkg is compiled first; the host model drives the stop pins
`include "clk_stop_defines.svh"
module test_clock_stop_powerdown_control;
  timeunit 1ns;
  timeprecision 100ps;
  import clk_stop_pkg::*;

  localparam int unsigned PDIV = 6;
  localparam int unsigned RDIV = 14;
  localparam int unsigned WAKE = 10; // short wake count keeps the run brief

  // one row: pin levels and config beside the outputs they should give
  typedef struct packed {
    logic cpu_n;
    logic pci_n;
    cfg_t c;
    logic rb;
    logic [1:0] cpu_run;
    logic pci_run;
    logic [2:0] free_run;
  } row_t;

  logic mclk, nrst, w_cpu, w_pci, w_pd, tpg;
  logic cpu_n, pci_n, pd_n, ref_clk, osc_pll_enable, pci_stop_readback;
  cfg_t cfg;
  logic [1:0] cpu_clk_true, cpu_clk_complement, cpu_compl_oe, tg_cpu;
  logic [2:0] cpu_drive_mult, pci_free_clk, tg_free;
  logic [5:0] pci_clk, tg_pci;
  logic tg_ref;
  row_t rows [6];
  int n_mismatch = 0;
  int total_checks = 0;
  int hi_pci = 0;
  int hi_ref = 0;
  int n;

  pm_host_model pm_host_model_i (.mclk(mclk), .want_cpu_stop(w_cpu), .want_pci_stop(w_pci),
    .want_pd(w_pd), .cpu_clock_stop_n(cpu_n), .pci_clock_stop_n(pci_n), .power_down_n(pd_n));

  clock_stop_powerdown_control #(.PCI_DIV(PDIV), .REF_DIV(RDIV), .WAKE_CYCLES(WAKE))
    clock_stop_powerdown_control_i (.mclk(mclk), .nrst(nrst), .cpu_clock_stop_n(cpu_n),
    .pci_clock_stop_n(pci_n), .power_down_n(pd_n), .termination_power_good(tpg), .cfg(cfg),
    .cpu_clk_true(cpu_clk_true), .cpu_clk_complement(cpu_clk_complement),
    .cpu_compl_oe(cpu_compl_oe), .cpu_drive_mult(cpu_drive_mult), .pci_clk(pci_clk),
    .pci_free_clk(pci_free_clk), .ref_clk(ref_clk), .osc_pll_enable(osc_pll_enable),
    .pci_stop_readback(pci_stop_readback));

  ////////////////////////////////////////////////////////////////////////////////
  // clock, 200 MHz
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // gather which outputs toggled over a span, sampled mid-cycle
  task automatic watch(input int len);
    logic [1:0] pc;
    logic [5:0] pp;
    logic [2:0] pf;
    logic pr;
    tg_cpu = '0;
    tg_pci = '0;
    tg_free = '0;
    tg_ref = 1'b0;
    pc = cpu_clk_true;
    pp = pci_clk;
    pf = pci_free_clk;
    pr = ref_clk;
    repeat (len) begin
      @(negedge mclk);
      tg_cpu |= pc ^ cpu_clk_true;
      tg_pci |= pp ^ pci_clk;
      tg_free |= pf ^ pci_free_clk;
      tg_ref |= pr ^ ref_clk;
      pc = cpu_clk_true;
      pp = pci_clk;
      pf = pci_free_clk;
      pr = ref_clk;
    end
  endtask : watch

  ////////////////////////////////////////////////////////////////////////////////
  // pci_clk[0] and ref_clk high phases never cut short or stretched, across stops and power-down
  always @(negedge mclk) begin
    if (!nrst) begin
      hi_pci = 0;
      hi_ref = 0;
    end else begin
      if (pci_clk[0] === 1'b1) hi_pci++;
      else if (hi_pci != 0) begin
        chk(8'(hi_pci), 8'(PDIV / 2));
        hi_pci = 0;
      end
      if (ref_clk === 1'b1) hi_ref++;
      else if (hi_ref != 0) begin
        chk(8'(hi_ref), 8'(RDIV / 2));
        hi_ref = 0;
      end
    end
  end

  // watchdog sized far above the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: reset, table of stop cases, then restart and power-down
  initial begin
    nrst = 1'b0;
    cfg = 7'h62;
    w_cpu = 1'b0;
    w_pci = 1'b0;
    w_pd = 1'b0;
    tpg = 1'b0;
    rows[0] = '{1'b1, 1'b1, 7'h62, 1'b1, 2'h3, 1'b1, 3'h7};
    rows[1] = '{1'b0, 1'b1, 7'h23, 1'b1, 2'h2, 1'b1, 3'h7};
    rows[2] = '{1'b0, 1'b1, 7'h42, 1'b1, 2'h1, 1'b1, 3'h7};
    rows[3] = '{1'b1, 1'b0, 7'h76, 1'b0, 2'h3, 1'b0, 3'h5};
    rows[4] = '{1'b1, 1'b1, 7'h69, 1'b0, 2'h3, 1'b0, 3'h2};
    rows[5] = '{1'b0, 1'b0, 7'h00, 1'b0, 2'h3, 1'b0, 3'h0};
    repeat (10) @(negedge mclk);
    chk(pci_stop_readback, 1'b1);
    chk(osc_pll_enable, 1'b1);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(negedge mclk);
      cfg <= rows[i].c;
      w_cpu <= !rows[i].cpu_n;
      w_pci <= !rows[i].pci_n;
      tpg <= !tpg; // toggled each row, must change nothing
      repeat (24) @(negedge mclk);
      watch(24);
      chk(tg_cpu, rows[i].cpu_run);
      chk(|tg_pci, rows[i].pci_run);
      chk(tg_free, rows[i].free_run);
      chk(pci_stop_readback, rows[i].rb);
      chk(cpu_drive_mult, rows[i].c.drive_current_select ? `DRIVE_X6 : `DRIVE_X4);
      chk(cpu_clk_true | rows[i].cpu_run, 2'h3);
      chk(cpu_clk_complement & ~rows[i].cpu_run, 2'h0);
      chk(cpu_compl_oe, rows[i].cpu_run);
      chk(tg_ref, 1'b1);
      if (!rows[i].pci_run) chk(pci_clk, 6'h00);
    end
    // cpu and pci restart latency from the request
    @(negedge mclk);
    cfg <= 7'h62;
    w_cpu <= 1'b1;
    w_pci <= 1'b1;
    repeat (24) @(negedge mclk);
    w_cpu <= 1'b0;
    w_pci <= 1'b0;
    n = 0;
    while (cpu_clk_true[0] === 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk(n <= 10, 1'b1);
    while (pci_clk[0] === 1'b0 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk(n <= 16, 1'b1);
    // power-down with every free clock set free-running
    cfg <= 7'h7E;
    w_pd <= 1'b1;
    n = 0;
    while (osc_pll_enable !== 1'b0 && n < 80) begin
      @(negedge mclk);
      n++;
    end
    chk(n < 80, 1'b1);
    watch(20);
    chk({tg_cpu, |tg_pci, tg_free, tg_ref}, 7'h00);
    chk({pci_clk, pci_free_clk, ref_clk, cpu_clk_complement}, 12'h000);
    chk(cpu_clk_true, 2'h3);
    chk(cpu_compl_oe, 2'h0);
    chk(cpu_drive_mult, `DRIVE_X2);
    w_pd <= 1'b0;
    n = 0;
    while (cpu_clk_true[0] === 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    chk(n <= WAKE + 12, 1'b1);
    chk(osc_pll_enable, 1'b1);
    watch(24);
    chk({tg_cpu, |tg_pci, tg_free, tg_ref}, 7'h7F);
    // mid-run reset: pll on, readback released, then every clock restarts with full pulses
    nrst <= 1'b0;
    repeat (3) @(negedge mclk);
    chk(osc_pll_enable, 1'b1);
    chk(pci_stop_readback, 1'b1);
    nrst <= 1'b1;
    watch(24);
    chk({tg_cpu, |tg_pci, tg_free, tg_ref}, 7'h7F);
    stop_test();
  end
endmodule : test_clock_stop_powerdown_control
